// ==== include/seh_pkg.sv ====
// constants for the hold and low-supply protect logic
package seh_pkg;
  localparam int         CLK_PERIOD_NS  = 10;
  localparam int         T_WRITE_NS     = 5000000;
  localparam int         WRITE_CYCLES   = T_WRITE_NS / CLK_PERIOD_NS;
  localparam int         BIT_W          = 3;
  localparam int         BYTE_W         = 4;
  localparam logic [2:0] BIT_LAST       = 3'h7;
  localparam logic [3:0] BYTE_MAX       = 4'hF;
  localparam logic [3:0] BYTES_CMD      = 4'h1;
  localparam logic [3:0] BYTES_SR_WRITE = 4'h2;
  localparam logic [3:0] BYTES_WRITE    = 4'h4;
  localparam logic [7:0] OP_WR_ENABLE   = 8'h06;
  localparam logic [7:0] OP_WR_DISABLE  = 8'h04;
  localparam logic [7:0] OP_RDSR        = 8'h05;
  localparam logic [7:0] OP_SR_WRITE    = 8'h01;
  localparam logic [7:0] OP_WRITE       = 8'h02;
  localparam int         SR_WIP         = 0;
  localparam int         SR_LATCH       = 1;
  localparam int         SR_BP0         = 2;
  localparam int         SR_BP1         = 3;
  localparam int         SR_SRWD        = 7;
  localparam logic [7:0] SR_RESET       = 8'h00;
  typedef enum logic [1:0] {
    SEH_IDLE,
    SEH_BUSY_ARRAY,
    SEH_BUSY_SR
  } seh_wr_e;
endpackage

// ==== include/seh_if.sv ====
// link signals shared between the core and the pause controller
`timescale 1ns/1ns
interface seh_if;
  logic cs_n_s;
  logic sck_s;
  logic hold_n_s;
  logic paused;
  logic sck_rise;
  logic sck_fall;
  modport ctl (input cs_n_s, input sck_s, input hold_n_s, output paused, output sck_rise, output sck_fall);
  modport core (output cs_n_s, output sck_s, output hold_n_s, input paused, input sck_rise, input sck_fall);
endinterface

// ==== hw/seh_hold_ctl.sv ====
// pause controller: tracks the hold state and gates serial clock edges
`timescale 1ns/1ns
module seh_hold_ctl (
  input wire logic clk,
  input wire logic rst_n,
  seh_if.ctl       lk
);
  logic sck_q;
  logic paused_q;
  logic paused_d;

  // pause follows hold only while sck is low, so a change made with sck high waits for its fall
  assign paused_d    = lk.cs_n_s ? 1'b0 : (!lk.sck_s ? !lk.hold_n_s : paused_q);
  assign lk.paused   = paused_q;
  // edges seen during a pause never reach the core
  assign lk.sck_rise = lk.sck_s & ~sck_q & ~paused_d;
  assign lk.sck_fall = ~lk.sck_s & sck_q & ~paused_d;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sck_q    <= 1'b0;
      paused_q <= 1'b0;
    end else begin
      sck_q    <= lk.sck_s;
      paused_q <= paused_d;
    end
  end

  a_hold_sck_low: assert property (@(posedge clk) disable iff (!rst_n)
    (!lk.sck_s && !lk.cs_n_s) |=> (lk.paused == !$past(lk.hold_n_s)))
    else $error("pause did not follow hold with sck low");
  a_hold_sck_high: assert property (@(posedge clk) disable iff (!rst_n)
    (lk.sck_s && $past(lk.sck_s) && !lk.cs_n_s && $past(!lk.cs_n_s)) |-> $stable(lk.paused))
    else $error("pause changed while sck high");
  a_pause_no_edge: assert property (@(posedge clk) disable iff (!rst_n)
    (lk.paused && !lk.cs_n_s && !lk.sck_s) |=> (lk.paused || !lk.sck_fall))
    else $error("clock edge passed during pause");
  c_hold_enter: cover property (@(posedge clk) disable iff (!rst_n) !lk.paused ##1 lk.paused);
endmodule // seh_hold_ctl

// ==== hw/seh_top.sv ====
// serial memory interface core with pause control and low-supply write lockout
`timescale 1ns/1ns
// Overview of operation
// - during a pause the serial output is released to high impedance
// - during a pause serial clock and data input are ignored
// - chip select raised during a pause ends the transaction with no write
// - hold falling with clock low starts the pause at once
// - hold rising with clock low ends the pause at once
// - hold falling with clock high starts the pause at next clock fall
// - hold rising with clock high ends the pause at next clock fall
// - power-up or supply drop aborts any array or status write
// - power-up or supply drop clears the write enable latch
// - no write ever starts while chip select stays high
// - serial output drives high, low or floats
module seh_top #(
  parameter int WRITE_CYCLES = seh_pkg::WRITE_CYCLES
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       cs_n,
  input  wire logic       sck,
  input  wire logic       si,
  input  wire logic       hold_n,
  input  wire logic       supply_low,
  output logic            so_o,
  output logic            so_oe_n,
  output logic            write_enable_latch,
  output logic            write_busy,
  output logic            write_start,
  output logic            write_abort,
  output logic [7:0]      status
);
  localparam int WTW = $clog2(WRITE_CYCLES + 1);
  // pins at their idle levels, so the sck edge finder sees no false edge after reset
  localparam logic [4:0] PIN_IDLE = 5'h0D;

  seh_if lk ();

  // two-stage synchronisers; stage one feeds stage two only
  logic [4:0] sync1_q;
  logic [4:0] sync2_q;
  logic       si_s;
  logic       low_s;
  logic       cs_prev_q;

  logic [7:0]             shift_q;
  logic [seh_pkg::BIT_W-1:0]  bits_q;
  logic [seh_pkg::BYTE_W-1:0] bytes_q;
  logic [7:0]             opcode_q;
  logic [7:0]             out_q;
  logic                   out_on_q;
  logic                   so_q;
  logic                   we_latch_q;
  logic [7:0]             sr_q;
  logic [7:0]             sr_new_q;
  logic [WTW-1:0]         timer_q;
  seh_pkg::seh_wr_e       wr_q;
  logic                   start_q;
  logic                   abort_q;

  assign lk.cs_n_s   = sync2_q[0];
  assign lk.sck_s    = sync2_q[1];
  assign lk.hold_n_s = sync2_q[3];
  assign si_s        = sync2_q[2];
  assign low_s       = sync2_q[4];

  seh_hold_ctl u_hold (
    .clk   (clk),
    .rst_n (rst_n),
    .lk    (lk)
  );

  // decode
  wire       cs_rise    = lk.cs_n_s & ~cs_prev_q;
  wire       byte_done  = lk.sck_rise && (bits_q == seh_pkg::BIT_LAST);
  wire [7:0] byte_in    = {shift_q[6:0], si_s};
  wire       idle       = (wr_q == seh_pkg::SEH_IDLE);
  wire       aligned    = (bits_q == '0);
  // a write starts only on the rising chip select of a complete, unpaused frame
  wire       go_array   = cs_rise && !lk.paused && idle && we_latch_q && aligned &&
                          (opcode_q == seh_pkg::OP_WRITE) && (bytes_q >= seh_pkg::BYTES_WRITE);
  wire       go_sr      = cs_rise && !lk.paused && idle && we_latch_q && aligned &&
                          (opcode_q == seh_pkg::OP_SR_WRITE) && (bytes_q == seh_pkg::BYTES_SR_WRITE);
  wire       timer_done = !idle && (timer_q == '0);
  wire [7:0] sr_view    = {sr_q[7:2], we_latch_q, !idle};

  assign so_o               = so_q;
  assign so_oe_n            = lk.cs_n_s | lk.paused | ~out_on_q;
  assign write_enable_latch = we_latch_q;
  assign write_busy         = !idle;
  assign write_start        = start_q;
  assign write_abort        = abort_q;
  assign status             = sr_view;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sync1_q   <= PIN_IDLE;
      sync2_q   <= PIN_IDLE;
      cs_prev_q <= 1'b1;
    end else begin
      sync1_q   <= {supply_low, hold_n, si, sck, cs_n};
      sync2_q   <= sync1_q;
      cs_prev_q <= lk.cs_n_s;
    end
  end

  // serial shifter; cleared while cs is high or supply is low, else frozen whenever no gated edge arrives, so a pause leaves it intact
  always_ff @(posedge clk) begin
    if (!rst_n || lk.cs_n_s || low_s) begin
      shift_q <= 8'h00;
      bits_q  <= '0;
      bytes_q <= '0;
    end else if (lk.sck_rise) begin
      shift_q <= byte_in;
      bits_q  <= bits_q + 1'b1;
      if (byte_done && bytes_q != seh_pkg::BYTE_MAX) begin
        bytes_q <= bytes_q + 1'b1;
      end
    end
  end

  // opcode and status capture
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      opcode_q <= 8'h00;
      sr_new_q <= seh_pkg::SR_RESET;
    end else if (lk.cs_n_s) begin
      opcode_q <= 8'h00;
    end else if (byte_done && bytes_q == '0) begin
      opcode_q <= byte_in;
    end else if (byte_done && bytes_q == seh_pkg::BYTES_CMD) begin
      sr_new_q <= byte_in;
    end
  end

  // status readout shifts on falling edges; reloaded each byte for repeated reads
  always_ff @(posedge clk) begin
    if (!rst_n || lk.cs_n_s) begin
      out_q    <= 8'h00;
      out_on_q <= 1'b0;
      so_q     <= 1'b0;
    end else if (byte_done && (out_on_q || (bytes_q == '0 && byte_in == seh_pkg::OP_RDSR))) begin
      out_q    <= sr_view;
      out_on_q <= 1'b1;
    end else if (lk.sck_fall && out_on_q) begin
      so_q  <= out_q[7];
      out_q <= {out_q[6:0], 1'b0};
    end
  end

  // write enable latch; the supply detector acts first and wins over everything
  always_ff @(posedge clk) begin
    if (!rst_n || low_s) begin
      we_latch_q <= 1'b0;
    end else if (timer_done) begin
      we_latch_q <= 1'b0;
    end else if (cs_rise && !lk.paused && idle && aligned && bytes_q == seh_pkg::BYTES_CMD) begin
      if (opcode_q == seh_pkg::OP_WR_ENABLE) begin
        we_latch_q <= 1'b1;
      end else if (opcode_q == seh_pkg::OP_WR_DISABLE) begin
        we_latch_q <= 1'b0;
      end
    end
  end

  // write timer; status bits change only when a status write completes
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_q    <= seh_pkg::SEH_IDLE;
      timer_q <= '0;
      sr_q    <= seh_pkg::SR_RESET;
      start_q <= 1'b0;
      abort_q <= 1'b0;
    end else begin
      start_q <= 1'b0;
      abort_q <= 1'b0;
      if (low_s) begin
        abort_q <= !idle;
        wr_q    <= seh_pkg::SEH_IDLE;
        timer_q <= '0;
      end else begin
        case (wr_q)
          seh_pkg::SEH_IDLE: begin
            if (go_array || go_sr) begin
              wr_q    <= go_sr ? seh_pkg::SEH_BUSY_SR : seh_pkg::SEH_BUSY_ARRAY;
              timer_q <= WTW'(WRITE_CYCLES - 1);
              start_q <= 1'b1;
            end
          end
          seh_pkg::SEH_BUSY_ARRAY, seh_pkg::SEH_BUSY_SR: begin
            if (timer_done) begin
              if (wr_q == seh_pkg::SEH_BUSY_SR) begin
                sr_q[seh_pkg::SR_SRWD] <= sr_new_q[seh_pkg::SR_SRWD];
                sr_q[seh_pkg::SR_BP1]  <= sr_new_q[seh_pkg::SR_BP1];
                sr_q[seh_pkg::SR_BP0]  <= sr_new_q[seh_pkg::SR_BP0];
              end
              wr_q <= seh_pkg::SEH_IDLE;
            end else begin
              timer_q <= timer_q - 1'b1;
            end
          end
          default: wr_q <= seh_pkg::SEH_IDLE;
        endcase
      end
    end
  end

  a_so_paused_float: assert property (@(posedge clk) disable iff (!rst_n)
    lk.paused |-> so_oe_n)
    else $error("serial output driven during pause");
  a_so_desel_float: assert property (@(posedge clk) disable iff (!rst_n)
    lk.cs_n_s |-> so_oe_n)
    else $error("serial output driven while deselected");
  a_supply_abort: assert property (@(posedge clk) disable iff (!rst_n)
    (low_s && !idle) |=> (write_abort && !write_busy))
    else $error("write survived a supply drop");
  a_supply_wel_clear: assert property (@(posedge clk) disable iff (!rst_n)
    low_s |=> !write_enable_latch)
    else $error("write enable latch survived a supply drop");
  a_pause_freeze: assert property (@(posedge clk) disable iff (!rst_n)
    (lk.paused && !lk.cs_n_s && !low_s) |=> ($stable(shift_q) && $stable(bits_q) && $stable(bytes_q)))
    else $error("shifter moved during pause");
  a_start_on_deselect: assert property (@(posedge clk) disable iff (!rst_n)
    write_start |-> ($past(lk.cs_n_s) && $past(cs_rise) && $past(we_latch_q)))
    else $error("write started without a chip select release");
  a_paused_release: assert property (@(posedge clk) disable iff (!rst_n)
    (cs_rise && lk.paused) |=> !write_start)
    else $error("write started from a paused frame");
  c_array_write: cover property (@(posedge clk) disable iff (!rst_n)
    write_start && wr_q == seh_pkg::SEH_BUSY_ARRAY);
  c_status_write: cover property (@(posedge clk) disable iff (!rst_n)
    write_start ##1 wr_q == seh_pkg::SEH_BUSY_SR);
  c_supply_abort: cover property (@(posedge clk) disable iff (!rst_n) write_abort);
  c_pause_release: cover property (@(posedge clk) disable iff (!rst_n) cs_rise && lk.paused);
endmodule // seh_top

// ==== verif/seh_host_model.sv ====
// host side model of the serial link, mode 0
`timescale 1ns/1ns
module seh_host_model (
  input  wire logic clk,
  input  wire logic so,
  output logic      cs_n,
  output logic      sck,
  output logic      si,
  output logic      hold_n
);
  initial begin
    cs_n   = 1'b1;
    sck    = 1'b0;
    si     = 1'b1;
    hold_n = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // pause is only raised inside a frame; the cs release scenario breaks this on purpose
  task automatic drive(input logic c, input logic h, input logic s);
    cs_n   <= c;
    hold_n <= h;
    sck    <= s;
  endtask
  task automatic xbyte(input logic [7:0] b, output logic [7:0] r);
    for (int i = 7; i >= 0; i--) begin
      sck <= 1'b0;
      si  <= b[i];
      tick(8);
      r[i] = so;
      sck <= 1'b1;
      tick(8);
    end
    sck <= 1'b0;
    si  <= ~b[0]; // no stale bit left on a released line
    tick(8);
  endtask
  task automatic frame(input logic [7:0] q[$], output logic [7:0] r);
    cs_n <= 1'b0;
    tick(8);
    foreach (q[k]) xbyte(q[k], r);
    cs_n <= 1'b1; // sck is low here, never raised together with cs
    tick(16);
  endtask
  // clock and data toggles that a paused device must ignore
  task automatic junk();
    repeat (3) begin
      sck <= 1'b1;
      si  <= ~si;
      tick(8);
      sck <= 1'b0;
      tick(8);
    end
  endtask
endmodule // seh_host_model

// ==== verif/tb_top.sv ====
// self-checking bench: pause control and low-supply write lockout
`timescale 1ns/1ns
module tb_top;
  localparam int WC = 60;
  logic       clk;
  logic       rst_n;
  logic       supply_low;
  logic       cs_n;
  logic       sck;
  logic       si;
  logic       hold_n;
  logic       so_o;
  logic       so_oe_n;
  logic       latch;
  logic       busy;
  logic       wstart;
  logic       wabort;
  logic [7:0] status;
  logic [7:0] r;
  wire        so_w = (so_oe_n === 1'b0) ? so_o : 1'bz;
  int         n_errors = 0;
  int         n_tests  = 0;
  int         n_start  = 0;
  int         n_abort  = 0;
  seh_top #(
    .WRITE_CYCLES (WC)
  ) DUT (
    .clk                (clk),
    .rst_n              (rst_n),
    .cs_n               (cs_n),
    .sck                (sck),
    .si                 (si),
    .hold_n             (hold_n),
    .supply_low         (supply_low),
    .so_o               (so_o),
    .so_oe_n            (so_oe_n),
    .write_enable_latch (latch),
    .write_busy         (busy),
    .write_start        (wstart),
    .write_abort        (wabort),
    .status             (status)
  );
  seh_host_model HOST (
    .clk    (clk),
    .so     (so_w),
    .cs_n   (cs_n),
    .sck    (sck),
    .si     (si),
    .hold_n (hold_n)
  );
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (wstart === 1'b1) n_start++;
    if (wabort === 1'b1) n_abort++;
  end
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic report_and_stop();
    if (n_errors == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic wait_idle();
    for (int k = 0; k < 200 && busy !== 1'b0; k++) @(posedge clk);
    if (busy !== 1'b0) begin
      n_errors++;
      $display("mismatch write_busy expected 0 seen %b", busy);
      report_and_stop();
    end
  endtask
  task automatic t_status_register_write_instruction();
    int s;
    HOST.frame({seh_pkg::OP_WR_ENABLE}, r);
    s = n_start;
    HOST.frame({seh_pkg::OP_SR_WRITE, 8'h8C}, r);
    chk("start", 8'(s + 1), 8'(n_start));
    wait_idle();
    chk("status", 8'h8C, status);
  endtask
  task automatic t_hold_low();
    HOST.drive(1'b0, 1'b1, 1'b0);
    HOST.tick(8);
    HOST.xbyte(seh_pkg::OP_RDSR, r);
    HOST.drive(1'b0, 1'b0, 1'b0);
    HOST.tick(5);
    chk("so_oe_n", 8'h01, {7'h00, so_oe_n});
    chk("so", {7'h00, 1'bz}, {7'h00, so_w});
    HOST.junk();
    HOST.drive(1'b0, 1'b1, 1'b0);
    HOST.tick(5);
    chk("so_oe_n", 8'h00, {7'h00, so_oe_n});
    HOST.xbyte(8'h00, r);
    chk("rdsr", 8'h8C, r);
    HOST.drive(1'b1, 1'b1, 1'b0);
    HOST.tick(16);
  endtask
  task automatic t_hold_high();
    HOST.drive(1'b0, 1'b1, 1'b0);
    HOST.tick(8);
    HOST.xbyte(seh_pkg::OP_RDSR, r);
    HOST.drive(1'b0, 1'b1, 1'b1);
    HOST.tick(8);
    HOST.drive(1'b0, 1'b0, 1'b1);
    HOST.tick(8);
    chk("so_oe_n", 8'h00, {7'h00, so_oe_n});
    HOST.drive(1'b0, 1'b0, 1'b0);
    HOST.tick(6);
    chk("so_oe_n", 8'h01, {7'h00, so_oe_n});
    HOST.junk();
    HOST.drive(1'b0, 1'b0, 1'b1);
    HOST.tick(8);
    HOST.drive(1'b0, 1'b1, 1'b1);
    HOST.tick(8);
    chk("so_oe_n", 8'h01, {7'h00, so_oe_n});
    HOST.drive(1'b0, 1'b1, 1'b0);
    HOST.tick(6);
    chk("so_oe_n", 8'h00, {7'h00, so_oe_n});
    HOST.drive(1'b1, 1'b1, 1'b0);
    HOST.tick(16);
  endtask
  task automatic t_cs_pause();
    int s;
    HOST.frame({seh_pkg::OP_WR_ENABLE}, r);
    s = n_start;
    HOST.drive(1'b0, 1'b1, 1'b0);
    HOST.tick(8);
    // a complete write frame: without the pause, raising cs here would start it
    HOST.xbyte(seh_pkg::OP_WRITE, r);
    HOST.xbyte(8'h00, r);
    HOST.xbyte(8'h10, r);
    HOST.xbyte(8'hA5, r);
    HOST.drive(1'b0, 1'b0, 1'b0);
    HOST.tick(6);
    chk("so_oe_n", 8'h01, {7'h00, so_oe_n});
    HOST.drive(1'b1, 1'b0, 1'b0);
    HOST.tick(4);
    HOST.drive(1'b1, 1'b1, 1'b0);
    HOST.tick(16);
    chk("start", 8'(s), 8'(n_start));
    chk("busy", 8'h00, {7'h00, busy});
  endtask
  task automatic t_cs_high();
    int s;
    HOST.frame({seh_pkg::OP_WR_ENABLE}, r);
    s = n_start;
    HOST.xbyte(seh_pkg::OP_WRITE, r);
    HOST.xbyte(8'hA5, r);
    HOST.tick(16);
    chk("start", 8'(s), 8'(n_start));
    chk("latch", 8'h01, {7'h00, latch});
    HOST.frame({seh_pkg::OP_WR_DISABLE}, r);
    chk("latch", 8'h00, {7'h00, latch});
  endtask
  task automatic t_supply();
    int s, a;
    HOST.frame({seh_pkg::OP_WR_ENABLE}, r);
    HOST.frame({seh_pkg::OP_WRITE, 8'h00, 8'h10, 8'hA5}, r);
    chk("busy", 8'h01, {7'h00, busy});
    a = n_abort;
    supply_low <= 1'b1;
    HOST.tick(6);
    chk("abort", 8'(a + 1), 8'(n_abort));
    chk("busy", 8'h00, {7'h00, busy});
    chk("latch", 8'h00, {7'h00, latch});
    supply_low <= 1'b0;
    HOST.tick(4);
    s = n_start;
    HOST.frame({seh_pkg::OP_WRITE, 8'h00, 8'h10, 8'hA5}, r);
    chk("start", 8'(s), 8'(n_start));
    HOST.frame({seh_pkg::OP_WR_ENABLE}, r);
    HOST.frame({seh_pkg::OP_WRITE, 8'h00, 8'h10, 8'hA5}, r);
    chk("start", 8'(s + 1), 8'(n_start));
    wait_idle();
  endtask
  initial begin
    rst_n      = 1'b0;
    supply_low = 1'b0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    HOST.tick(4);
    chk("latch", 8'h00, {7'h00, latch});
    t_status_register_write_instruction();
    t_hold_low();
    t_hold_high();
    t_cs_pause();
    t_cs_high();
    t_supply();
    report_and_stop();
  end
endmodule // tb_top
